/* File: design/sbcfw_status_bank.sv */
// Purpose: Fault, bus and wake status flags read and cleared by the host
// Assumes: All inputs except rst_n synchronous to sys_clk; monitor events are pulses
// Notes: Clear access is a one-cycle strobe with the register address
`timescale 1ns/10ps
module sbcfw_status_bank
  import sbcfw_pkg::*;
#(
  parameter int TX_ENABLE_CYC = SBCFW_TX_ENABLE_CYC,
  parameter int IRQ_PULSE_CYC = SBCFW_IRQ_PULSE_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Power-on reset
  input wire logic soft_reset, // Soft reset command pulse
  input wire logic restart_entry, // Entering restart pulse
  input wire logic restart_from_sleep, // Restart cause is sleep
  input wire logic failsafe_wake, // Wake out of fail-safe pulse
  input wire logic [6:0] reg_addr, // Register address
  input wire logic reg_clear, // Read-and-clear strobe
  output logic [7:0] reg_rdata, // Read data
  input wire logic [1:0] config_select, // Configuration 1..4 as 0..3
  input wire logic wdog_fail_event, // Watchdog trigger failure
  input wire logic wd_trigger_ok, // Successful watchdog trigger
  input wire logic fail_release, // Fail output release request
  output logic fail_output, // Fail output active
  input wire logic invalid_cmd, // Invalid command detected
  input wire logic thermal_shutdown, // Transceiver overtemperature
  input wire logic txd_dom_detect, // Transmit dominant timeout seen
  input wire logic bus_dom_detect, // Bus dominant timeout seen
  input wire logic txd_high, // Transmit input level high
  input wire logic bus_recessive, // Bus level recessive
  input wire logic can_off_or_wake, // Transceiver off or wake-capable
  input wire logic can_supply_low, // Supply under threshold
  input wire logic can_mode_one, // CAN mode bit one
  input wire logic selective_wake, // Selective wake enabled
  input wire logic can_bus_silence, // Bus silence indication
  input wire logic can_timeout_irq_mask, // Timeout interrupt enable
  input wire logic stop_or_normal, // Device in stop or normal mode
  input wire logic sel_wake_cfg_error, // Selective wake config error
  input wire logic sel_wake_err_overflow, // Error counter above 32
  input wire logic can_wake, // CAN bus wake event
  input wire logic timer_wake, // Timer wake event
  input wire logic wake_input_event, // Wake input event
  output logic can_tx_enable, // Transmitter may drive
  output logic interrupt_out_low, // Interrupt output, low active
  output logic [1:0] watchdog_failure_count // Counter value
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] wdc;
    logic wd_frozen;
    logic fail_out;
    logic [1:0] pre_restart_state;
    logic spi_fail;
    logic failure;
    logic timeout_flag;
    logic timeout_lock;
    logic sys_error;
    logic [1:0] can_fail;
    logic uv_flag;
    logic thermal_act;
    logic txd_act;
    logic bus_act;
    logic [15:0] txen_cnt;
    logic tx_en;
    logic [2:0] wake;
    sbcfw_irq_state_t irq;
    logic [15:0] irq_cnt;
    logic [7:0] rdata;
  } sbcfw_state_t;

  localparam sbcfw_state_t SBCFW_STATE_RST = '{
    wdc: SBCFW_WDC_ZERO, wd_frozen: 1'b0, fail_out: 1'b0,
    pre_restart_state: SBCFW_PRE_CLEARED, spi_fail: 1'b0,
    failure: 1'b0, timeout_flag: 1'b0, timeout_lock: 1'b0,
    sys_error: 1'b0, can_fail: SBCFW_CANF_NONE, uv_flag: 1'b0,
    thermal_act: 1'b0,
    txd_act: 1'b0, bus_act: 1'b0, txen_cnt: 16'h0000, tx_en: 1'b1,
    wake: 3'h0, irq: SBCFW_IRQ_IDLE, irq_cnt: 16'h0000,
    rdata: SBCFW_RESET_VALUE
  };

  sbcfw_state_t s_q;
  sbcfw_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_int_n;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  function automatic logic clr_hit(input logic [6:0] a,
                                   input logic [6:0] target,
                                   input logic strobe);
    clr_hit = strobe && (a == target);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic clr_dev;
  logic clr_bus;
  logic clr_wk;
  logic [1:0] wd_limit;
  logic wd_freeze_cfg;
  logic uv_now;
  logic timeout_set;
  logic [2:0] wake_evt;
  logic fault_any;

  always_comb begin
    s_d = s_q;
    clr_dev = clr_hit(reg_addr, SBCFW_ADDR_DEV_INFO, reg_clear);
    clr_bus = clr_hit(reg_addr, SBCFW_ADDR_BUS_COMM, reg_clear);
    clr_wk = clr_hit(reg_addr, SBCFW_ADDR_WAKE_0, reg_clear);
    wd_limit = (config_select == SBCFW_CFG_2) ? SBCFW_WDC_ONE :
               SBCFW_WDC_TWO;
    wd_freeze_cfg = (config_select == SBCFW_CFG_2) ||
                    (config_select == SBCFW_CFG_4);
    uv_now = can_mode_one && can_supply_low;
    timeout_set = selective_wake && can_bus_silence;
    wake_evt = {can_wake, timer_wake, wake_input_event};

    // Watchdog counter: frozen in configs 2/4 until a good trigger
    if (wd_trigger_ok) begin
      s_d.wd_frozen = 1'b0;
    end
    if (wdog_fail_event && !(s_q.wd_frozen && wd_freeze_cfg)) begin
      if (s_q.wdc < wd_limit) begin
        s_d.wdc = s_q.wdc + 2'h1;
      end
      s_d.wd_frozen = wd_freeze_cfg;
    end
    if (s_d.wdc == wd_limit && wdog_fail_event) begin
      s_d.fail_out = 1'b1;
    end
    if (fail_release && !wdog_fail_event) begin
      s_d.fail_out = 1'b0;
      s_d.wdc = SBCFW_WDC_ZERO;
    end

    // Device status flags, set wins over clear
    if (clr_dev) begin
      s_d.spi_fail = 1'b0;
      s_d.failure = 1'b0;
      s_d.pre_restart_state = SBCFW_PRE_CLEARED;
    end
    if (invalid_cmd) begin
      s_d.spi_fail = 1'b1;
    end
    if (s_d.fail_out && !s_q.fail_out) begin
      s_d.failure = 1'b1;
    end
    if (restart_entry) begin
      s_d.pre_restart_state = restart_from_sleep ? SBCFW_PRE_SLEEP :
                              SBCFW_PRE_FAILURE;
    end else if (failsafe_wake) begin
      s_d.pre_restart_state = SBCFW_PRE_FAILURE;
    end

    // CAN fault conditions and their recovery
    if (txd_high || can_off_or_wake) begin
      s_d.txd_act = 1'b0;
    end
    if (bus_recessive || can_off_or_wake) begin
      s_d.bus_act = 1'b0;
    end
    s_d.thermal_act = thermal_shutdown;
    if (txd_dom_detect) begin
      s_d.txd_act = 1'b1;
    end
    if (bus_dom_detect) begin
      s_d.bus_act = 1'b1;
    end

    if (clr_bus) begin
      s_d.can_fail = SBCFW_CANF_NONE;
      s_d.uv_flag = 1'b0;
      s_d.sys_error = 1'b0;
      if (!s_q.timeout_lock) begin
        s_d.timeout_flag = 1'b0;
      end
    end
    if (bus_dom_detect) begin
      s_d.can_fail = SBCFW_CANF_BUS_DOM;
    end else if (txd_dom_detect) begin
      s_d.can_fail = SBCFW_CANF_TXD_DOM;
    end else if (thermal_shutdown && !s_q.thermal_act) begin
      s_d.can_fail = SBCFW_CANF_THERMAL;
    end
    if (uv_now) begin
      s_d.uv_flag = 1'b1;
    end
    if (selective_wake && (sel_wake_cfg_error || sel_wake_err_overflow)) begin
      s_d.sys_error = 1'b1;
    end

    // Transmitter re-enable after transmit input held high
    fault_any = s_d.thermal_act || s_d.txd_act || s_d.bus_act || uv_now;
    if (fault_any) begin
      s_d.tx_en = 1'b0;
      s_d.txen_cnt = 16'h0000;
    end else if (!s_q.tx_en) begin
      if (!txd_high) begin
        s_d.txen_cnt = 16'h0000;
      end else if (s_q.txen_cnt >= 16'(TX_ENABLE_CYC - 1)) begin
        s_d.tx_en = 1'b1;
      end else begin
        s_d.txen_cnt = s_q.txen_cnt + 16'h0001;
      end
    end

    // Timeout flag and interrupt pulse
    if (timeout_set) begin
      s_d.timeout_flag = 1'b1;
      if (!s_q.timeout_flag && can_timeout_irq_mask && stop_or_normal) begin
        s_d.timeout_lock = 1'b1;
      end
    end
    case (s_q.irq)
      SBCFW_IRQ_IDLE: begin
        if (s_q.timeout_lock) begin
          s_d.irq = SBCFW_IRQ_PULSE;
          s_d.irq_cnt = 16'h0000;
          s_d.timeout_lock = 1'b0;
        end
      end
      SBCFW_IRQ_PULSE: begin
        if (s_q.irq_cnt >= 16'(IRQ_PULSE_CYC - 1)) begin
          s_d.irq = SBCFW_IRQ_IDLE;
        end else begin
          s_d.irq_cnt = s_q.irq_cnt + 16'h0001;
        end
      end
      default: begin
        s_d.irq = SBCFW_IRQ_IDLE;
      end
    endcase

    // Wake source flags
    for (int i = 0; i < 3; i++) begin
      if (clr_wk) begin
        s_d.wake[i] = 1'b0;
      end
      if (wake_evt[i]) begin
        s_d.wake[i] = 1'b1;
      end
    end

    // Restart keeps bus bits 4:0; bits 7:5 are reserved here
    // Soft reset returns all state except the read data to the power-on value
    if (soft_reset) begin
      s_d = SBCFW_STATE_RST;
    end

    // Registered read data, reserved bits zero
    s_d.rdata = 8'h00;
    case (reg_addr)
      SBCFW_ADDR_DEV_INFO: begin
        s_d.rdata[SBCFW_DEV_PRE_LSB +: 2] = s_q.pre_restart_state;
        s_d.rdata[SBCFW_DEV_WDC_LSB +: 2] = s_q.wdc;
        s_d.rdata[SBCFW_DEV_SPIF_BIT] = s_q.spi_fail;
        s_d.rdata[SBCFW_DEV_FAIL_BIT] = s_q.failure;
      end
      SBCFW_ADDR_BUS_COMM: begin
        s_d.rdata[SBCFW_BUS_TIMEOUT_BIT] = s_q.timeout_flag;
        s_d.rdata[SBCFW_BUS_SYS_ERROR_BIT] = s_q.sys_error;
        s_d.rdata[SBCFW_BUS_FAIL_LSB +: 2] = s_q.can_fail;
        s_d.rdata[SBCFW_BUS_UV_BIT] = s_q.uv_flag;
      end
      SBCFW_ADDR_WAKE_0: begin
        s_d.rdata[SBCFW_WK_CAN_BIT] = s_q.wake[2];
        s_d.rdata[SBCFW_WK_TIMER_BIT] = s_q.wake[1];
        s_d.rdata[SBCFW_WK_INPUT_BIT] = s_q.wake[0];
      end
      default: begin
        s_d.rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_q <= SBCFW_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign fail_output = s_q.fail_out;
  assign can_tx_enable = s_q.tx_en;
  assign interrupt_out_low = (s_q.irq != SBCFW_IRQ_PULSE);
  assign watchdog_failure_count = s_q.wdc;

endmodule

/* File: include/sbcfw_pkg.sv */
// Purpose: Constants and types for the fault and wake status bank
// Assumes: Register offsets are the printed 7-bit register addresses
// Notes: Timing figures are given in ns and converted to 100 MHz cycles
package sbcfw_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] SBCFW_ADDR_DEV_INFO = 7'h43;
  localparam logic [6:0] SBCFW_ADDR_BUS_COMM = 7'h44;
  localparam logic [6:0] SBCFW_ADDR_WAKE_0 = 7'h46;
  localparam logic [7:0] SBCFW_RESET_VALUE = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SBCFW_DEV_PRE_LSB = 6;
  localparam int SBCFW_DEV_WDC_LSB = 2;
  localparam int SBCFW_DEV_SPIF_BIT = 1;
  localparam int SBCFW_DEV_FAIL_BIT = 0;
  localparam int SBCFW_BUS_TIMEOUT_BIT = 4;
  localparam int SBCFW_BUS_SYS_ERROR_BIT = 3;
  localparam int SBCFW_BUS_FAIL_LSB = 1;
  localparam int SBCFW_BUS_UV_BIT = 0;
  localparam int SBCFW_WK_CAN_BIT = 5;
  localparam int SBCFW_WK_TIMER_BIT = 4;
  localparam int SBCFW_WK_INPUT_BIT = 0;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] SBCFW_PRE_CLEARED = 2'h0;
  localparam logic [1:0] SBCFW_PRE_FAILURE = 2'h1;
  localparam logic [1:0] SBCFW_PRE_SLEEP = 2'h2;
  localparam logic [1:0] SBCFW_CANF_NONE = 2'h0;
  localparam logic [1:0] SBCFW_CANF_THERMAL = 2'h1;
  localparam logic [1:0] SBCFW_CANF_TXD_DOM = 2'h2;
  localparam logic [1:0] SBCFW_CANF_BUS_DOM = 2'h3;
  localparam logic [1:0] SBCFW_WDC_ZERO = 2'h0;
  localparam logic [1:0] SBCFW_WDC_ONE = 2'h1;
  localparam logic [1:0] SBCFW_WDC_TWO = 2'h2;
  // Configuration select: 0..3 stand for configurations 1..4
  localparam logic [1:0] SBCFW_CFG_2 = 2'h1;
  localparam logic [1:0] SBCFW_CFG_4 = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SBCFW_CLK_PERIOD_NS = 10;
  localparam int SBCFW_TX_ENABLE_NS = 4000;
  localparam int SBCFW_TX_ENABLE_CYC =
    (SBCFW_TX_ENABLE_NS + SBCFW_CLK_PERIOD_NS - 1) / SBCFW_CLK_PERIOD_NS;
  localparam int SBCFW_IRQ_PULSE_NS = 100;
  localparam int SBCFW_IRQ_PULSE_CYC =
    (SBCFW_IRQ_PULSE_NS + SBCFW_CLK_PERIOD_NS - 1) / SBCFW_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SBCFW_IRQ_IDLE = 2'b01,
    SBCFW_IRQ_PULSE = 2'b10
  } sbcfw_irq_state_t;

endpackage

/* File: tb/sbcfw_host_model.sv */
// Purpose: Host model issuing register read-and-clear accesses
// Assumes: Clear strobe is taken at a rising edge
// Notes: Address is held between accesses
`timescale 1ns/10ps
module sbcfw_host_model (
  input wire logic sys_clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  output logic [6:0] reg_addr, // Address
  output logic reg_clear // Clear strobe
);
  // ****************************************
  // Access
  // ****************************************
  initial begin
    reg_addr = 7'h00;
    reg_clear = 1'b0;
  end
  task automatic rd_clr(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_clear = 1'b1;
    @(negedge sys_clk);
    d = reg_rdata;
    reg_clear = 1'b0;
  endtask
endmodule

/* File: tb/sbcfw_status_bank_sva.sv */
// Purpose: Port-level timing checks on the status bank
// Assumes: Bound into sbcfw_status_bank
// Notes: Long spans are counted in helper counters
`timescale 1ns/10ps
module sbcfw_status_bank_sva
  import sbcfw_pkg::*;
#(
  parameter int TX_ENABLE_CYC = 4,
  parameter int IRQ_PULSE_CYC = 2
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic soft_reset, // Soft reset
  input wire logic fail_release, // Fail release
  input wire logic wdog_fail_event, // Watchdog failure
  input wire logic wd_trigger_ok, // Good trigger
  input wire logic [1:0] config_select, // Configuration
  input wire logic [6:0] reg_addr, // Address
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic fail_output, // Fail output
  input wire logic [1:0] watchdog_failure_count, // Counter
  input wire logic can_mode_one, // CAN mode bit one
  input wire logic can_supply_low, // Supply low
  input wire logic can_tx_enable, // Transmit enable
  input wire logic txd_high, // Transmit input high
  input wire logic interrupt_out_low // Interrupt output
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      hi_q <= txd_high ? hi_q + 16'h0001 : 16'h0000;
      lo_q <= interrupt_out_low ? 16'h0000 : lo_q + 16'h0001;
    end
  end
  function automatic logic [7:0] used(logic [6:0] a);
    return a == SBCFW_ADDR_DEV_INFO ? 8'hcf : a == SBCFW_ADDR_BUS_COMM ?
      8'h1f : a == SBCFW_ADDR_WAKE_0 ? 8'h31 : 8'h00;
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wd_counted;
    config_select == SBCFW_CFG_4 && wdog_fail_event && !soft_reset &&
      !fail_release && watchdog_failure_count == 2'h0;
  endsequence
  sequence s_wd_again;
    config_select == SBCFW_CFG_4 && wdog_fail_event && !wd_trigger_ok &&
      !soft_reset && !fail_release;
  endsequence
  property p_wdc;
    watchdog_failure_count != 2'h3;
  endproperty
  a_wdc: assert property (p_wdc) else $error("counter at 3");
  property p_cfg2;
    wdog_fail_event && config_select == SBCFW_CFG_2 && !soft_reset &&
      !fail_release && watchdog_failure_count == 2'h0
      |=> fail_output && watchdog_failure_count == 2'h1;
  endproperty
  a_cfg2: assert property (p_cfg2) else $error("one-fail limit");
  property p_cfg13;
    wdog_fail_event && !config_select[0] && !soft_reset && !fail_release &&
      watchdog_failure_count == 2'h1
      |=> fail_output && watchdog_failure_count == 2'h2;
  endproperty
  a_cfg13: assert property (p_cfg13) else $error("two-fail limit");
  property p_frz;
    s_wd_counted ##1 !wd_trigger_ok ##1 s_wd_again
      |=> watchdog_failure_count == 2'h1;
  endproperty
  a_frz: assert property (p_frz) else $error("counter not frozen");
  property p_uv;
    can_mode_one && can_supply_low && !soft_reset |=> !can_tx_enable;
  endproperty
  a_uv: assert property (p_uv) else $error("transmitter kept on");
  property p_tx;
    $rose(can_tx_enable) && !$past(soft_reset)
      |-> hi_q >= TX_ENABLE_CYC - 1;
  endproperty
  a_tx: assert property (p_tx) else $error("enable too early");
  property p_pulse;
    $rose(interrupt_out_low) |-> lo_q == IRQ_PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_resv;
    (reg_rdata & ~used($past(reg_addr))) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule
bind sbcfw_status_bank sbcfw_status_bank_sva #(
  .TX_ENABLE_CYC(TX_ENABLE_CYC), .IRQ_PULSE_CYC(IRQ_PULSE_CYC)
) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(soft_reset),
  .fail_release(fail_release), .wdog_fail_event(wdog_fail_event),
  .wd_trigger_ok(wd_trigger_ok), .config_select(config_select),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .fail_output(fail_output),
  .watchdog_failure_count(watchdog_failure_count),
  .can_mode_one(can_mode_one), .can_supply_low(can_supply_low),
  .can_tx_enable(can_tx_enable), .txd_high(txd_high),
  .interrupt_out_low(interrupt_out_low)
);

/* File: tb/tb_sbcfw_status_bank.sv */
// Purpose: Self-checking bench for the status bank
// Assumes: Host model performs every register access
// Notes: Short enable and pulse counts keep the run brief
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_sbcfw_status_bank
  import sbcfw_pkg::*;
;
  localparam int TXC = 4;
  localparam int IRQC = 2;
  localparam logic [6:0] DV = SBCFW_ADDR_DEV_INFO;
  localparam logic [6:0] BS = SBCFW_ADDR_BUS_COMM;
  localparam logic [6:0] WK = SBCFW_ADDR_WAKE_0;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [12:0] lv = 13'h040c;
  logic [1:0] cfg = 2'h0;
  logic [2:0] r;
  logic [6:0] reg_addr;
  logic [7:0] reg_rdata;
  logic [1:0] wdc;
  logic reg_clear, fail_output, can_tx_enable, interrupt_out_low;
  int bad_count = 0;
  int total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  // ****************************************
  // Harness
  // ****************************************
  sbcfw_status_bank #(.TX_ENABLE_CYC(TXC), .IRQ_PULSE_CYC(IRQC)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(ev[0]),
    .restart_entry(ev[1]), .restart_from_sleep(lv[0]),
    .failsafe_wake(ev[2]), .reg_addr(reg_addr), .reg_clear(reg_clear),
    .reg_rdata(reg_rdata), .config_select(cfg), .wdog_fail_event(ev[3]),
    .wd_trigger_ok(ev[4]), .fail_release(ev[5]), .fail_output(fail_output),
    .invalid_cmd(ev[6]), .thermal_shutdown(lv[1]), .txd_dom_detect(ev[7]),
    .bus_dom_detect(ev[8]), .txd_high(lv[2]), .bus_recessive(lv[3]),
    .can_off_or_wake(lv[4]), .can_supply_low(lv[5]), .can_mode_one(lv[6]),
    .selective_wake(lv[7]), .can_bus_silence(lv[8]),
    .can_timeout_irq_mask(lv[9]), .stop_or_normal(lv[10]),
    .sel_wake_cfg_error(lv[11]), .sel_wake_err_overflow(lv[12]),
    .can_wake(ev[9]), .timer_wake(ev[10]), .wake_input_event(ev[11]),
    .can_tx_enable(can_tx_enable), .interrupt_out_low(interrupt_out_low),
    .watchdog_failure_count(wdc));
  sbcfw_host_model u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_clear(reg_clear));
  function automatic logic [7:0] wexp(logic [2:0] w);
    return {2'h0, w[0], w[1], 3'h0, w[2]};
  endfunction
  task automatic pls(input int i);
    @(negedge sys_clk);
    ev[i] = 1'b1;
    @(negedge sys_clk);
    ev[i] = 1'b0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd_clr(a, d);
    `CHK("reg_rdata", e, d)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(30));
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    rc(DV, 8'h00);
    rc(BS, 8'h00);
    rc(WK, 8'h00);
    rc(7'h45, 8'h00);
    pls(6);
    rc(DV, 8'h02);
    rc(DV, 8'h00);
    pls(3);
    pls(3);
    `CHK("fail_output", 1'b1, fail_output)
    rc(DV, {4'h0, SBCFW_WDC_TWO, 2'h1});
    rc(DV, {4'h0, SBCFW_WDC_TWO, 2'h0});
    pls(5);
    cfg = SBCFW_CFG_2;
    pls(3);
    `CHK("watchdog_failure_count", SBCFW_WDC_ONE, wdc)
    `CHK("fail_output", 1'b1, fail_output)
    pls(5);
    pls(4);
    cfg = SBCFW_CFG_4;
    pls(3);
    pls(3);
    `CHK("watchdog_failure_count", SBCFW_WDC_ONE, wdc)
    pls(4);
    pls(3);
    `CHK("watchdog_failure_count", SBCFW_WDC_TWO, wdc)
    rc(DV, {4'h0, SBCFW_WDC_TWO, 2'h1});
    pls(5);
    pls(4);
    for (int s = 0; s < 3; s++) begin
      if (s == 1) pls(9);
      lv[0] = s[0];
      pls(s == 2 ? 2 : 1);
      rc(DV, {(s == 1 ? SBCFW_PRE_SLEEP : SBCFW_PRE_FAILURE), 6'h00});
    end
    rc(WK, wexp(3'h1));
    lv[3:2] = 2'h0;
    pls(7);
    rc(BS, {5'h00, SBCFW_CANF_TXD_DOM, 1'b0});
    `CHK("can_tx_enable", 1'b0, can_tx_enable)
    lv[2] = 1'b1;
    pls(8);
    rc(BS, {5'h00, SBCFW_CANF_BUS_DOM, 1'b0});
    repeat (TXC + 2) @(negedge sys_clk);
    `CHK("can_tx_enable", 1'b0, can_tx_enable)
    lv[4] = 1'b1;
    repeat (TXC + 2) @(negedge sys_clk);
    `CHK("can_tx_enable", 1'b1, can_tx_enable)
    lv[4:3] = 2'h1;
    lv[1] = 1'b1;
    rc(BS, {5'h00, SBCFW_CANF_THERMAL, 1'b0});
    lv[1] = 1'b0;
    lv[6:5] = 2'h3;
    rc(BS, 8'h01);
    `CHK("can_tx_enable", 1'b0, can_tx_enable)
    lv[2] = 1'b0;
    lv[5] = 1'b0;
    rc(BS, 8'h01);
    rc(BS, 8'h00);
    `CHK("can_tx_enable", 1'b0, can_tx_enable)
    lv[2] = 1'b1;
    repeat (TXC - 1) @(negedge sys_clk);
    `CHK("can_tx_enable", 1'b0, can_tx_enable)
    @(negedge sys_clk);
    `CHK("can_tx_enable", 1'b1, can_tx_enable)
    lv[6:5] = 2'h1;
    rc(BS, 8'h00);
    lv[5] = 1'b0;
    for (int s = 0; s < 4; s++) begin
      lv[7] = s[1];
      lv[11 + s[0]] = 1'b1;
      @(negedge sys_clk);
      lv[12:11] = 2'h0;
      rc(BS, {4'h0, s[1], 3'h0});
    end
    for (int m = 1; m >= 0; m--) begin
      lv[9] = m[0];
      @(negedge sys_clk);
      lv[8] = 1'b1;
      fork
        rc(BS, 8'h10);
        begin
          @(negedge sys_clk);
          lv[8] = 1'b0;
        end
      join
      `CHK("interrupt_out_low", ~m[0], interrupt_out_low)
      repeat (IRQC + 4) @(negedge sys_clk);
      rc(BS, {3'h0, m[0], 4'h0});
    end
    repeat (8) begin
      r = 3'($urandom);
      ev[11:9] = r;
      @(negedge sys_clk);
      ev[11:9] = 3'h0;
      rc(WK, wexp(r));
    end
    pls(9);
    pls(0);
    rc(WK, 8'h00);
    end_of_test();
  end
endmodule
